// file: rtl/timing_status_params.svh
// Register offsets, field positions, reset values and codes of the timing status bank
`ifndef TIMING_STATUS_PARAMS_SVH
`define TIMING_STATUS_PARAMS_SVH

// Offsets are word indices: the byte address on the bus is four times the index
`define OFS_INTERRUPT_STATUS_BYTE2   8'h08
`define OFS_OPERATING_STATE_STATUS   8'h09
`define OFS_PRIORITY_TABLE_LOW       8'h0a
`define OFS_PRIORITY_TABLE_HIGH      8'h0b
`define OFS_INTERRUPT_MASK           8'h20
`define OFS_CONTROL                  8'h24

`define RST_INTERRUPT_STATUS_BYTE2   8'h50
`define RST_OPERATING_STATE_STATUS   8'h41
`define RST_PRIORITY_TABLE           8'h00
`define RST_INTERRUPT_MASK           8'h00
`define RST_CONTROL                  8'h02

`define BIT_L1_LOS                   0
`define BIT_L1_VIOL                  1
`define BIT_L2_LOS                   2
`define BIT_L2_VIOL                  3
`define BIT_SYNC_ALARM               7
`define BIT_SEC_LOCK                 6
`define BIT_MAIN_WARN                5
`define BIT_SEC_WARN                 4
`define BIT_CTL_PATH_SEL             0
`define BIT_CTL_PHASE_DET_EN         1

`define CODE_NONE                    4'h0
`define NUM_INPUTS                   14

`endif

// file: rtl/timing_status_pkg.sv
// Types shared by the timing status bank
package timing_status_pkg;
    typedef enum logic [2:0] {
        MODE_UNUSED0    = 3'h0,
        MODE_FREE_RUN   = 3'h1,
        MODE_HOLDOVER   = 3'h2,
        MODE_UNUSED3    = 3'h3,
        MODE_LOCKED     = 3'h4,
        MODE_PRE_LOCK2  = 3'h5,
        MODE_PRE_LOCK   = 3'h6,
        MODE_PHASE_LOST = 3'h7
    } pll_mode_type;
    typedef enum logic [1:0] {
        AHB_IDLE,
        AHB_DATA
    } ahb_phase_type;
endpackage

// file: rtl/priority_rank.sv
// Ranks the validated inputs into the three highest priorities
`timescale 1ns/1ps
`include "timing_status_params.svh"
module priority_rank
    import timing_status_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic [13:0] valid_in,
    input  wire logic [55:0] prio_in,
    output logic      [3:0]  first_reg,
    output logic      [3:0]  second_reg,
    output logic      [3:0]  third_reg
);
    logic [3:0] f_next;
    logic [3:0] s_next;
    logic [3:0] t_next;
    logic [3:0] fp;
    logic [3:0] sp;
    logic [3:0] tp;

    // Lower priority value wins; zero priority disables; ties go to the lower input
    always_comb begin
        f_next = `CODE_NONE;
        s_next = `CODE_NONE;
        t_next = `CODE_NONE;
        fp = 4'hf;
        sp = 4'hf;
        tp = 4'hf;
        for (int i = 0; i < `NUM_INPUTS; i++) begin
            if (valid_in[i] && prio_in[i*4 +: 4] != 4'h0) begin
                if (f_next == `CODE_NONE || prio_in[i*4 +: 4] < fp) begin
                    t_next = s_next;
                    tp = sp;
                    s_next = f_next;
                    sp = fp;
                    f_next = 4'(i + 1);
                    fp = prio_in[i*4 +: 4];
                end else if (s_next == `CODE_NONE || prio_in[i*4 +: 4] < sp) begin
                    t_next = s_next;
                    tp = sp;
                    s_next = 4'(i + 1);
                    sp = prio_in[i*4 +: 4];
                end else if (t_next == `CODE_NONE || prio_in[i*4 +: 4] < tp) begin
                    t_next = 4'(i + 1);
                    tp = prio_in[i*4 +: 4];
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            first_reg <= `CODE_NONE;
            second_reg <= `CODE_NONE;
            third_reg <= `CODE_NONE;
        end else begin
            first_reg <= f_next;
            second_reg <= s_next;
            third_reg <= t_next;
        end
    end
endmodule

// file: rtl/timing_status_regs.sv
// Timing status register bank with AHB-Lite slave and interrupt
//
// Function
// - Line signal-loss events on inputs one and two latch bits 0 and 2.
// - Line code violations on inputs one and two latch bits 1 and 3.
// - Writing one clears a latched bit; zero leaves it; new event re-sets.
// - Operating bit 7 shows live frame-sync monitor alarm.
// - Operating bit 5 shows main PLL beyond soft frequency limit.
// - Operating bit 4 shows secondary PLL beyond soft frequency limit.
// - Operating bits 2..0 encode the main PLL state-machine mode.
// - Selected and highest-priority inputs may differ; no forced match.
// - High table lower nibble gives second-highest valid input, else 0.
// - High table upper nibble gives third-highest valid input, else 0.
// - Path-select bit chooses main (0) or secondary (1) view.
`timescale 1ns/1ps
`include "timing_status_params.svh"
module timing_status_regs
    import timing_status_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             irq,
    input  wire logic        line1_signal_loss_event,
    input  wire logic        line2_signal_loss_event,
    input  wire logic        line1_code_violation_event,
    input  wire logic        line2_code_violation_event,
    input  wire logic        other_event_sync,
    input  wire logic        other_event_secondary_status,
    input  wire logic        other_event_phase_monitor,
    input  wire logic        other_event_secondary_no_input,
    input  wire logic        frame_sync_monitor_alarm,
    input  wire logic        secondary_pll_locked,
    input  wire logic        secondary_cycle_slip,
    input  wire logic        main_pll_freq_warn,
    input  wire logic        secondary_pll_freq_warn,
    input  wire logic [2:0]  main_pll_state,
    input  wire logic [13:0] main_path_valid,
    input  wire logic [13:0] secondary_path_valid,
    input  wire logic [55:0] main_path_priority,
    input  wire logic [55:0] secondary_path_priority,
    input  wire logic [3:0]  main_path_selected,
    input  wire logic [3:0]  secondary_path_selected,
    output logic             path_view_select,
    output logic             phase_detector_enable
);
    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    ahb_phase_type phase_reg;
    logic [7:0]    addr_reg;
    logic          write_reg;
    logic          rd_pulse_next;
    logic          wr_strobe;
    logic [7:0]    irq_status_reg;
    logic [7:0]    irq_mask_reg;
    logic [7:0]    control_reg;
    logic [7:0]    operating_reg;
    logic [7:0]    table_low_reg;
    logic [7:0]    table_high_reg;
    logic          slip_hold_reg;
    logic          det_en_prev_reg;
    logic [7:0]    event_vec;
    logic [7:0]    clear_vec;
    logic [7:0]    rd_next;
    logic [3:0]    first_code;
    logic [3:0]    second_code;
    logic [3:0]    third_code;
    logic [13:0]   view_valid;
    logic [55:0]   view_priority;

    assign rd_pulse_next = hsel && hready && htrans[1];
    assign wr_strobe     = (phase_reg == AHB_DATA) && write_reg;

    // Single-cycle address capture; data phase never waits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_reg <= AHB_IDLE;
            addr_reg <= 8'h00;
            write_reg <= 1'b0;
        end else begin
            phase_reg <= rd_pulse_next ? AHB_DATA : AHB_IDLE;
            if (rd_pulse_next) begin
                addr_reg <= haddr[9:2];
                write_reg <= hwrite;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Read data registered in the address phase so it stands in the data phase
    always_comb begin
        rd_next = 8'h00;
        case (haddr[9:2])
            `OFS_INTERRUPT_STATUS_BYTE2: rd_next = irq_status_reg;
            `OFS_OPERATING_STATE_STATUS: rd_next = operating_reg;
            `OFS_PRIORITY_TABLE_LOW:     rd_next = table_low_reg;
            `OFS_PRIORITY_TABLE_HIGH:    rd_next = table_high_reg;
            `OFS_INTERRUPT_MASK:         rd_next = irq_mask_reg;
            `OFS_CONTROL:                rd_next = control_reg;
            default:                     rd_next = 8'h00;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_pulse_next && !hwrite) begin
            hrdata <= {24'h00_0000, rd_next};
        end else begin
            hrdata <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Writable control and mask
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            control_reg <= `RST_CONTROL;
            irq_mask_reg <= `RST_INTERRUPT_MASK;
        end else if (wr_strobe) begin
            if (addr_reg == `OFS_CONTROL) begin
                control_reg <= {6'h00, hwdata[1:0]};
            end
            if (addr_reg == `OFS_INTERRUPT_MASK) begin
                irq_mask_reg <= hwdata[7:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            path_view_select <= 1'b0;
            phase_detector_enable <= 1'b1;
        end else begin
            path_view_select <= control_reg[`BIT_CTL_PATH_SEL];
            phase_detector_enable <= control_reg[`BIT_CTL_PHASE_DET_EN];
        end
    end

    // ------------------------------------------------------------
    // Latched interrupt status
    // ------------------------------------------------------------
    always_comb begin
        event_vec = 8'h00;
        event_vec[`BIT_L1_LOS] = line1_signal_loss_event;
        event_vec[`BIT_L2_LOS] = line2_signal_loss_event;
        event_vec[`BIT_L1_VIOL] = line1_code_violation_event;
        event_vec[`BIT_L2_VIOL] = line2_code_violation_event;
        event_vec[4] = other_event_secondary_no_input;
        event_vec[5] = other_event_phase_monitor;
        event_vec[6] = other_event_secondary_status;
        event_vec[7] = other_event_sync;
    end

    assign clear_vec = (wr_strobe && addr_reg == `OFS_INTERRUPT_STATUS_BYTE2) ? hwdata[7:0] : 8'h00;

    // A new event in the clearing cycle wins over the clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status_reg <= `RST_INTERRUPT_STATUS_BYTE2;
        end else begin
            irq_status_reg <= (irq_status_reg & ~clear_vec) | event_vec;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status_reg & irq_mask_reg);
        end
    end

    // ------------------------------------------------------------
    // Operating state
    // ------------------------------------------------------------
    // Slip hold clears only on a rising edge of the detector enable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slip_hold_reg <= 1'b0;
            det_en_prev_reg <= 1'b1;
        end else begin
            det_en_prev_reg <= control_reg[`BIT_CTL_PHASE_DET_EN];
            if (control_reg[`BIT_CTL_PHASE_DET_EN] && secondary_cycle_slip) begin
                slip_hold_reg <= 1'b1;
            end else if (control_reg[`BIT_CTL_PHASE_DET_EN] && !det_en_prev_reg) begin
                slip_hold_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            operating_reg <= `RST_OPERATING_STATE_STATUS;
        end else begin
            operating_reg[`BIT_SYNC_ALARM] <= frame_sync_monitor_alarm;
            operating_reg[`BIT_SEC_LOCK] <= secondary_pll_locked && !slip_hold_reg;
            operating_reg[`BIT_MAIN_WARN] <= main_pll_freq_warn;
            operating_reg[`BIT_SEC_WARN] <= secondary_pll_freq_warn;
            operating_reg[3] <= 1'b0;
            operating_reg[2:0] <= main_pll_state;
        end
    end

    // ------------------------------------------------------------
    // Priority table
    // ------------------------------------------------------------
    assign view_valid = control_reg[`BIT_CTL_PATH_SEL] ? secondary_path_valid : main_path_valid;
    assign view_priority = control_reg[`BIT_CTL_PATH_SEL] ? secondary_path_priority : main_path_priority;

    priority_rank u_rank (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .valid_in   (view_valid),
        .prio_in    (view_priority),
        .first_reg  (first_code),
        .second_reg (second_code),
        .third_reg  (third_code)
    );

    // Selected input reported as given, never forced to the top rank
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            table_low_reg <= `RST_PRIORITY_TABLE;
            table_high_reg <= `RST_PRIORITY_TABLE;
        end else begin
            table_low_reg[7:4] <= first_code;
            table_low_reg[3:0] <= control_reg[`BIT_CTL_PATH_SEL] ? secondary_path_selected
                                                                 : main_path_selected;
            table_high_reg[3:0] <= second_code;
            table_high_reg[7:4] <= third_code;
        end
    end
endmodule

// file: testbench/timing_status_regs_assertions.sv
// Port-level checks for the timing status register bank
`timescale 1ns/1ps
`include "timing_status_params.svh"
module timing_status_regs_assertions
    import timing_status_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hrdata,
    input wire logic        frame_sync_monitor_alarm,
    input wire logic        main_pll_freq_warn,
    input wire logic        secondary_pll_freq_warn,
    input wire logic [2:0]  main_pll_state,
    input wire logic        secondary_cycle_slip,
    input wire logic [3:0]  main_path_selected,
    input wire logic [3:0]  secondary_path_selected,
    input wire logic        path_view_select,
    input wire logic        phase_detector_enable
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    logic       rd_taken;
    logic [7:0] rd_index;
    logic [5:0] op_live;
    logic       slip_held_reg;
    assign rd_taken = hsel && htrans[1] && !hwrite;
    assign rd_index = haddr[9:2];
    assign op_live  = {frame_sync_monitor_alarm, main_pll_freq_warn, secondary_pll_freq_warn, main_pll_state};
    // Dropped on disable, so nothing is claimed across a re-enable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slip_held_reg <= 1'b0;
        end else if (!phase_detector_enable) begin
            slip_held_reg <= 1'b0;
        end else if (secondary_cycle_slip) begin
            slip_held_reg <= 1'b1;
        end
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Inputs held two cycles so the one-cycle input register cannot blur the value
    sequence op_read_steady;
        rd_taken && rd_index == `OFS_OPERATING_STATE_STATUS && $stable(op_live) && $past(op_live) == $past(op_live, 2);
    endsequence
    chk_sync_alarm_live: assert property (op_read_steady |=> hrdata[7] == $past(op_live[5]))
        else $error("sync alarm bit wrong");
    chk_main_warn_live: assert property (op_read_steady |=> hrdata[5] == $past(op_live[4]))
        else $error("main warn bit wrong");
    chk_sec_warn_live: assert property (op_read_steady |=> hrdata[4] == $past(op_live[3]))
        else $error("secondary warn bit wrong");
    chk_mode_code: assert property (op_read_steady |=> hrdata[2:0] == $past(op_live[2:0]))
        else $error("mode field wrong");
    chk_lock_held_low: assert property (rd_taken && rd_index == `OFS_OPERATING_STATE_STATUS && $past(slip_held_reg)
        |=> !hrdata[6]) else $error("lock bit not held low");
    chk_selected_main: assert property ((!path_view_select && $stable(main_path_selected)) [*3]
        ##0 (rd_taken && rd_index == `OFS_PRIORITY_TABLE_LOW) |=> hrdata[3:0] == $past(main_path_selected))
        else $error("main selected field wrong");
    chk_selected_second: assert property ((path_view_select && $stable(secondary_path_selected)) [*3]
        ##0 (rd_taken && rd_index == `OFS_PRIORITY_TABLE_LOW) |=> hrdata[3:0] == $past(secondary_path_selected))
        else $error("secondary selected field wrong");
    chk_rdata_upper_zero: assert property ($past(rd_taken) |-> hrdata[31:8] == 24'h00_0000)
        else $error("read data upper bits set");
    chk_rdata_idle: assert property (!$past(rd_taken) |-> hrdata == 32'h0000_0000)
        else $error("read data outside data phase");
    cov_op_read: cover property (op_read_steady);
    cov_path_second: cover property (path_view_select && rd_taken);
    cov_slip: cover property (secondary_cycle_slip && phase_detector_enable);
endmodule

bind timing_status_regs timing_status_regs_assertions timing_status_regs_assertions_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hrdata(hrdata), .frame_sync_monitor_alarm(frame_sync_monitor_alarm),
    .main_pll_freq_warn(main_pll_freq_warn), .secondary_pll_freq_warn(secondary_pll_freq_warn),
    .main_pll_state(main_pll_state), .secondary_cycle_slip(secondary_cycle_slip),
    .main_path_selected(main_path_selected), .secondary_path_selected(secondary_path_selected),
    .path_view_select(path_view_select), .phase_detector_enable(phase_detector_enable)
);

// file: testbench/tb.sv
// Self-checking testbench for the timing status register bank
`timescale 1ns/1ps
`include "timing_status_params.svh"
module tb
    import timing_status_pkg::*;
;
    localparam logic [31:0] ZERO = 32'h0000_0000;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize, pll_state;
    logic [7:0]  ev;
    logic        sync_alarm, locked, slip, main_warn, sec_warn, path_sel, det_en;
    logic [13:0] main_valid, sec_valid;
    logic [55:0] main_prio, sec_prio;
    logic [3:0]  main_sel, sec_sel;
    int          n_mismatch, n_tests;
    assign hready = hreadyout;
    timing_status_regs timing_status_regs_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .irq(irq), .line1_signal_loss_event(ev[0]), .line1_code_violation_event(ev[1]),
        .line2_signal_loss_event(ev[2]), .line2_code_violation_event(ev[3]), .other_event_sync(ev[7]),
        .other_event_secondary_status(ev[6]), .other_event_phase_monitor(ev[5]),
        .other_event_secondary_no_input(ev[4]), .frame_sync_monitor_alarm(sync_alarm),
        .secondary_pll_locked(locked), .secondary_cycle_slip(slip), .main_pll_freq_warn(main_warn),
        .secondary_pll_freq_warn(sec_warn), .main_pll_state(pll_state), .main_path_valid(main_valid),
        .secondary_path_valid(sec_valid), .main_path_priority(main_prio), .secondary_path_priority(sec_prio),
        .main_path_selected(main_sel), .secondary_path_selected(sec_sel), .path_view_select(path_sel),
        .phase_detector_enable(det_en)
    );
    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask
    // Called just after an edge; waits on hready, never on a fixed count
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {22'h00_0000, idx, 2'b00};
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp, input string what);
        logic [31:0] d;
        xfer(1'b0, idx, ZERO, d);
        check(what, d, exp);
        check("bus response", {30'h0000_0000, hreadyout, hresp}, 32'h0000_0002);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        logic [31:0] d;
        xfer(1'b1, idx, wd, d);
    endtask
    task automatic pulse_ev(input logic [7:0] v);
        ev <= v;
        tick(1);
        ev <= 8'h00;
        tick(2);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        rdc(`OFS_INTERRUPT_STATUS_BYTE2, 32'h0000_0050, "status");
        rdc(`OFS_OPERATING_STATE_STATUS, 32'h0000_0041, "operating");
        rdc(`OFS_PRIORITY_TABLE_LOW, ZERO, "table low");
        rdc(`OFS_PRIORITY_TABLE_HIGH, ZERO, "table high");
        rdc(`OFS_CONTROL, 32'h0000_0002, "control");
        wr(`OFS_OPERATING_STATE_STATUS, 32'h0000_00ff);
        rdc(`OFS_OPERATING_STATE_STATUS, 32'h0000_0041, "operating ro");
        rdc(8'h30, ZERO, "unmapped");
    endtask
    task automatic t_status();
        logic [31:0] e;
        wr(`OFS_INTERRUPT_STATUS_BYTE2, 32'h0000_00ff);
        rdc(`OFS_INTERRUPT_STATUS_BYTE2, ZERO, "status cleared");
        for (int i = 0; i < 8; i++) begin
            e = 32'h0000_0001 << i;
            pulse_ev(e[7:0]);
            rdc(`OFS_INTERRUPT_STATUS_BYTE2, e, "status set");
            wr(`OFS_INTERRUPT_STATUS_BYTE2, ZERO);
            rdc(`OFS_INTERRUPT_STATUS_BYTE2, e, "status kept");
            wr(`OFS_INTERRUPT_STATUS_BYTE2, e);
            rdc(`OFS_INTERRUPT_STATUS_BYTE2, ZERO, "status clear");
        end
        // Event in the clearing write's data phase must win over the clear
        fork
            wr(`OFS_INTERRUPT_STATUS_BYTE2, 32'h0000_0001);
            begin
                tick(1);
                ev <= 8'h01;
                tick(1);
                ev <= 8'h00;
            end
        join
        rdc(`OFS_INTERRUPT_STATUS_BYTE2, 32'h0000_0001, "set over clear");
        wr(`OFS_INTERRUPT_STATUS_BYTE2, 32'h0000_0001);
    endtask
    task automatic t_irq();
        pulse_ev(8'h02);
        check("irq masked", 32'(irq), ZERO);
        wr(`OFS_INTERRUPT_MASK, 32'h0000_0002);
        tick(2);
        check("irq on", 32'(irq), 32'h0000_0001);
        wr(`OFS_INTERRUPT_STATUS_BYTE2, 32'h0000_0002);
        tick(2);
        check("irq cleared", 32'(irq), ZERO);
        wr(`OFS_INTERRUPT_MASK, ZERO);
    endtask
    task automatic t_oper();
        logic [2:0] m;
        for (int i = 0; i < 8; i++) begin
            m = 3'(i);
            sync_alarm <= m[0];
            locked <= ~m[0];
            main_warn <= m[1];
            sec_warn <= m[2];
            pll_state <= m;
            tick(3);
            rdc(`OFS_OPERATING_STATE_STATUS, {24'h00_0000, m[0], ~m[0], m[1], m[2], 1'b0, m}, "oper");
        end
        sync_alarm <= 1'b0;
        locked <= 1'b1;
        main_warn <= 1'b0;
        sec_warn <= 1'b0;
        pll_state <= 3'h4;
        tick(3);
    endtask
    task automatic t_slip();
        slip <= 1'b1;
        tick(1);
        slip <= 1'b0;
        tick(3);
        rdc(`OFS_OPERATING_STATE_STATUS, 32'h0000_0004, "lock held");
        wr(`OFS_CONTROL, ZERO);
        tick(2);
        check("detector off", 32'(det_en), ZERO);
        wr(`OFS_CONTROL, 32'h0000_0002);
        tick(2);
        rdc(`OFS_OPERATING_STATE_STATUS, 32'h0000_0044, "lock back");
    endtask
    // Tie on priority 1 between inputs 7 and 9; input 1 valid but disabled
    task automatic t_table();
        main_valid <= 14'h0945;
        main_prio <= 56'h11_9121_2111_1510;
        main_sel <= 4'h4;
        sec_valid <= 14'h0002;
        sec_prio <= 56'h00_0000_0000_0030;
        tick(4);
        rdc(`OFS_PRIORITY_TABLE_LOW, 32'h0000_0074, "main low");
        rdc(`OFS_PRIORITY_TABLE_HIGH, 32'h0000_0039, "main high");
        wr(`OFS_CONTROL, 32'h0000_0003);
        tick(4);
        check("path select", 32'(path_sel), 32'h0000_0001);
        rdc(`OFS_PRIORITY_TABLE_LOW, 32'h0000_0020, "sec low");
        rdc(`OFS_PRIORITY_TABLE_HIGH, ZERO, "sec high");
        wr(`OFS_CONTROL, 32'h0000_0002);
    endtask
    task automatic wrap_up();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Clock, sequence and watchdog
    // ----------------------------------------
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata, ev, slip, sync_alarm, main_warn, sec_warn} = '0;
        {main_valid, sec_valid, main_prio, sec_prio, main_sel, sec_sel} = '0;
        hsize = 3'b010;
        locked = 1'b1;
        pll_state = 3'h1;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        tick(2);
        t_reset();
        t_status();
        t_irq();
        t_oper();
        t_slip();
        t_table();
        wrap_up();
    end
    // The tests need well under a thousand cycles
    initial begin
        repeat (20000) @(posedge hclk);
        n_mismatch++;
        wrap_up();
    end
endmodule
